// >>> rtl/lic_pkg.sv
// shared constants and types for the line interface control and status registers
package lic_pkg;
   localparam int             LIC_ADDR_W      = 6;
   localparam int             LIC_REG_W       = 4;
   localparam int             LIC_DATA_W      = 8;
   localparam int             LIC_CNT_W       = 16;
   localparam int             LIC_RUN_W       = 3;
   // register offsets inside one port's block
   localparam logic [3:0]     OFS_GLOBAL_CFG  = 4'h0;
   localparam logic [3:0]     OFS_TX_CFG      = 4'h1;
   localparam logic [3:0]     OFS_RX_CFG      = 4'h2;
   localparam logic [3:0]     OFS_RT_STATUS   = 4'h3;
   localparam logic [3:0]     OFS_LAT_STATUS  = 4'h4;
   localparam logic [3:0]     OFS_IRQ_EN      = 4'h5;
   localparam logic [3:0]     OFS_CV_LOW      = 4'h6;
   localparam logic [3:0]     OFS_CV_HIGH     = 4'h7;
   // writable bits and reset values
   localparam logic [7:0]     GCFG_MASK       = 8'hFD;
   localparam logic [7:0]     GCFG_RST        = 8'h00;
   localparam logic [7:0]     GCFG_RESET_BIT  = 8'h01;
   localparam logic [7:0]     TCFG_MASK       = 8'h7E;
   localparam logic [7:0]     TCFG_RST        = 8'h04;
   localparam logic [7:0]     RCFG_MASK       = 8'hFF;
   localparam logic [7:0]     RCFG_RST        = 8'h04;
   localparam logic [7:0]     LAT_MASK        = 8'h3F;
   localparam logic [7:0]     IEN_MASK        = 8'h3F;
   localparam logic [7:0]     ZERO8           = 8'h00;
   // field positions
   localparam int             B_EURO          = 7;
   localparam int             B_SONET         = 6;
   localparam int             B_LOCAL_LOOP    = 5;
   localparam int             B_REMOTE_LOOP   = 4;
   localparam int             B_TX_SEL_A      = 3;
   localparam int             B_TX_SEL_B      = 2;
   localparam int             B_PORT_RESET    = 0;
   localparam int             B_TX_BIN        = 6;
   localparam int             B_TX_CINV       = 5;
   localparam int             B_TX_JA         = 4;
   localparam int             B_TX_PD         = 3;
   localparam int             B_TX_TS         = 2;
   localparam int             B_TX_LBO        = 1;
   localparam int             B_VMODE         = 7;
   localparam int             B_RX_BIN        = 6;
   localparam int             B_RX_CINV       = 5;
   localparam int             B_RX_JA         = 4;
   localparam int             B_RX_PD         = 3;
   localparam int             B_RX_TS         = 2;
   localparam int             B_RX_MON        = 1;
   localparam int             B_CV_UPD        = 0;
   // status and latched bit positions
   localparam int             B_DRV_FAULT     = 5;
   localparam int             B_PAT_SYNC      = 4;
   localparam int             B_PAT_ERR       = 3;
   localparam int             B_CV            = 2;
   localparam int             B_PLL           = 1;
   localparam int             B_LOS           = 0;
   // excessive-zero thresholds
   localparam logic [2:0]     EXZ_RUN_US      = 3'h3;
   localparam logic [2:0]     EXZ_RUN_EURO    = 3'h4;
   localparam logic [2:0]     RUN_MAX         = 3'h7;
   localparam logic [15:0]    CNT_MAX         = 16'hFFFF;
   localparam logic [15:0]    CNT_ONE         = 16'h0001;

   typedef enum logic [1:0] {LIC_MODE_DS3, LIC_MODE_E3, LIC_MODE_STS1} lic_mode_e;
   typedef enum logic [1:0] {LIC_LOOP_NONE, LIC_LOOP_REMOTE, LIC_LOOP_ANALOG,
                             LIC_LOOP_DIGITAL} lic_loop_e;

   // per-port line-side inputs, all asynchronous to clk
   typedef struct packed {
      logic drv_fault;
      logic pattern_oos;
      logic pll_unlocked;
      logic signal_lost;
      logic bit_error;
      logic bpv_any;
      logic bpv_same_pol;
      logic rx_zero;
      logic rx_bit_tgl;
      logic tx_tristate_pin_n;
      logic rx_tristate_pin_n;
   } lic_stat_s;

   // per-port control outputs toward the analogue and datapath sections
   typedef struct packed {
      lic_mode_e mode;
      logic      ds3_ais_alt;
      lic_loop_e loop_sel;
      logic      tx_data_sel_a;
      logic      tx_data_sel_b;
      logic      port_reset;
      logic      tx_binary_if;
      logic      tx_clock_invert;
      logic      tx_jitter_atten_en;
      logic      rx_jitter_atten_en;
      logic      tx_power_down;
      logic      tx_line_hiz;
      logic      tx_build_out;
      logic      rx_binary_if;
      logic      rx_clock_invert;
      logic      rx_power_down;
      logic      rx_out_hiz;
      logic      monitor_preamp_en;
      logic      rx_violation_out;
   } lic_ctrl_s;

   localparam int             LIC_STAT_W      = $bits(lic_stat_s);
endpackage : lic_pkg

// >>> rtl/lic_sync.sv
// two-stage synchroniser for a vector of asynchronous levels
`timescale 1ns/1ps
module lic_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // only the second stage is visible; the first one may be metastable
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : lic_sync

// >>> rtl/lic_regs.sv
// per-port control/status register bank behind the parallel cpu bus
`timescale 1ns/1ps
module lic_regs
   import lic_pkg::*;
#(
   parameter int NUM_PORTS = 4
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  cpu_cs_n,
   input  wire logic                  cpu_wr_n,
   input  wire logic                  cpu_rd_n,
   input  wire logic [LIC_ADDR_W-1:0] cpu_addr,
   input  wire logic [LIC_DATA_W-1:0] cpu_wdata,
   output logic      [LIC_DATA_W-1:0] cpu_rdata,
   output logic                       cpu_rdata_oe_n,
   output logic                       int_n,
   input  wire lic_stat_s             stat_in  [NUM_PORTS],
   output lic_ctrl_s                  ctrl_out [NUM_PORTS]
);
   localparam int BUS_W = 3 + LIC_ADDR_W + LIC_DATA_W;
   localparam int PORT_W = LIC_ADDR_W - LIC_REG_W;

   // idle levels of the line inputs
   localparam lic_stat_s STAT_IDLE = '{pll_unlocked: 1'b1, signal_lost: 1'b1,
      tx_tristate_pin_n: 1'b1, rx_tristate_pin_n: 1'b1,
      default: 1'b0};

   // bus pins come from the host's timing domain, so they pass two flops
   logic [BUS_W-1:0]        bus_raw;
   logic [BUS_W-1:0]        bus_s;
   logic                    cs_s;
   logic                    wr_s;
   logic                    rd_s;
   logic [LIC_ADDR_W-1:0]   addr_s;
   logic [LIC_DATA_W-1:0]   wdata_s;
   logic                    wr_act;
   logic                    wr_act_q;
   logic                    wr_go;
   logic                    rd_act;
   logic [PORT_W-1:0]       bus_port;
   logic [LIC_REG_W-1:0]    bus_reg;
   logic [LIC_DATA_W-1:0]   rdata_d;
   logic [LIC_DATA_W-1:0]   rd_port   [NUM_PORTS];
   logic [NUM_PORTS-1:0]    irq_port;

   assign bus_raw  = {~cpu_cs_n, ~cpu_wr_n, ~cpu_rd_n, cpu_addr, cpu_wdata};

   lic_sync #(.W(BUS_W)) u_bus_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (bus_raw),
      .q     (bus_s)
   );

   assign {cs_s, wr_s, rd_s, addr_s, wdata_s} = bus_s;
   assign wr_act   = cs_s & wr_s;
   assign rd_act   = cs_s & rd_s & ~wr_s;
   // one write per strobe, taken on its first synchronised cycle
   assign wr_go    = wr_act & ~wr_act_q;
   assign bus_port = addr_s[LIC_ADDR_W-1:LIC_REG_W];
   assign bus_reg  = addr_s[LIC_REG_W-1:0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_act_q <= 1'b0;
      end else begin
         wr_act_q <= wr_act;
      end
   end

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         lic_stat_s            st;
         lic_stat_s            st_x;
         logic                 hit;
         logic [7:0]           gcfg_q;
         logic [7:0]           tcfg_q;
         logic [7:0]           rcfg_q;
         logic [7:0]           lat_q;
         logic [7:0]           ien_q;
         logic [7:0]           gcfg_w;
         logic [7:0]           gcfg_d;
         logic [7:0]           tcfg_d;
         logic [7:0]           rcfg_d;
         logic [7:0]           lat_d;
         logic [7:0]           ien_d;
         logic [7:0]           lat_set;
         logic [7:0]           lat_clr;
         logic [7:0]           rt_stat;
         logic                 srst;
         logic                 is_euro;
         logic                 is_sonet;
         logic                 drv_q;
         logic                 pat_q;
         logic                 pll_q;
         logic                 los_q;
         logic                 berr_q;
         logic                 tgl_q;
         logic                 bit_ev;
         logic [LIC_RUN_W-1:0] run_q;
         logic [LIC_RUN_W-1:0] run_d;
         logic [LIC_RUN_W-1:0] run_inc;
         logic [LIC_RUN_W-1:0] exz_thr;
         logic                 exz_ev;
         logic                 cv_ev;
         logic                 upd_q;
         logic                 upd_ev;
         logic [LIC_CNT_W-1:0] cnt_q;
         logic [LIC_CNT_W-1:0] cnt_d;
         logic [LIC_CNT_W-1:0] cnt_inc;
         logic [LIC_CNT_W-1:0] snap_q;
         logic [LIC_CNT_W-1:0] snap_d;
         lic_ctrl_s            ctrl_d;

         lic_sync #(.W(LIC_STAT_W)) u_stat_sync (
            .clk   (clk),
            .rst_n (rst_n),
            .d     (stat_in[p] ^ STAT_IDLE),
            .q     (st_x)
         );

         // reset of the flops shows idle levels
         assign st = st_x ^ STAT_IDLE;

         assign hit    = wr_go && (bus_port == PORT_W'(p));
         assign srst   = gcfg_q[B_PORT_RESET];

         // writes mask reserved positions, which the host keeps at zero
         assign gcfg_w = (hit && bus_reg == OFS_GLOBAL_CFG) ? (wdata_s & GCFG_MASK) : gcfg_q;
         // reset bit survives its own soft reset, everything else goes back to its reset value
         assign gcfg_d = srst ? ((GCFG_RST & ~GCFG_RESET_BIT) | (gcfg_w & GCFG_RESET_BIT))
                              : gcfg_w;
         assign tcfg_d = srst ? TCFG_RST
                       : (hit && bus_reg == OFS_TX_CFG) ? (wdata_s & TCFG_MASK) : tcfg_q;
         assign rcfg_d = srst ? RCFG_RST
                       : (hit && bus_reg == OFS_RX_CFG) ? (wdata_s & RCFG_MASK) : rcfg_q;
         assign ien_d  = srst ? ZERO8
                       : (hit && bus_reg == OFS_IRQ_EN) ? (wdata_s & IEN_MASK) : ien_q;

         // mode decode
         assign is_euro  = gcfg_q[B_EURO] & ~gcfg_q[B_SONET];
         assign is_sonet = gcfg_q[B_EURO] & gcfg_q[B_SONET];

         // excessive zeros: one event per run, at the threshold zero
         assign bit_ev  = st.rx_bit_tgl ^ tgl_q;
         assign exz_thr = is_euro ? EXZ_RUN_EURO : EXZ_RUN_US;
         assign run_inc = (run_q == RUN_MAX) ? run_q : run_q + LIC_RUN_W'(1);
         assign exz_ev  = bit_ev & st.rx_zero & (run_inc == exz_thr);
         assign run_d   = srst ? '0 : !bit_ev ? run_q : st.rx_zero ? run_inc : '0;

         // itu-style mode counts same-polarity violations in e3 and drops zeros
         assign cv_ev = bit_ev & (rcfg_q[B_VMODE]
                                  ? (is_euro ? st.bpv_same_pol : st.bpv_any)
                                  : (st.bpv_any | exz_ev));

         // counter snapshot on the update bit's rising edge
         assign upd_ev  = rcfg_q[B_CV_UPD] & ~upd_q;
         // saturates, never wraps
         assign cnt_inc = (cnt_q == CNT_MAX) ? cnt_q : cnt_q + CNT_ONE;
         // a violation in the snapshot cycle starts the new count, not lost
         assign cnt_d   = srst ? '0
                       : upd_ev ? (cv_ev ? CNT_ONE : '0)
                       : cv_ev ? cnt_inc : cnt_q;
         assign snap_d  = srst ? '0 : upd_ev ? cnt_q : snap_q;

         // reserved bits read zero
         assign rt_stat = {2'b00, st.drv_fault, st.pattern_oos, 2'b00,
                           st.pll_unlocked, st.signal_lost};

         always_comb begin
            lat_set               = ZERO8;
            lat_set[B_DRV_FAULT]  = st.drv_fault ^ drv_q;
            lat_set[B_PAT_SYNC]   = st.pattern_oos ^ pat_q;
            lat_set[B_PAT_ERR]    = st.bit_error & ~berr_q & ~st.pattern_oos;
            lat_set[B_CV]         = cv_ev;
            lat_set[B_PLL]        = st.pll_unlocked ^ pll_q;
            lat_set[B_LOS]        = st.signal_lost ^ los_q;
         end

         assign lat_clr = (hit && bus_reg == OFS_LAT_STATUS) ? wdata_s : ZERO8;
         // a new event in the clearing cycle keeps the bit set
         assign lat_d   = srst ? ZERO8 : (((lat_q & ~lat_clr) | lat_set) & LAT_MASK);

         // enabled latched bits only; clear or disable drops it next cycle
         assign irq_port[p] = |(lat_q & ien_q);

         always_comb begin
            ctrl_d                    = '0;
            ctrl_d.mode               = !gcfg_q[B_EURO] ? LIC_MODE_DS3
                                      : is_sonet ? LIC_MODE_STS1 : LIC_MODE_E3;
            ctrl_d.ds3_ais_alt        = ~gcfg_q[B_EURO] & gcfg_q[B_SONET];
            ctrl_d.loop_sel           = lic_loop_e'({gcfg_q[B_LOCAL_LOOP],
                                                     gcfg_q[B_REMOTE_LOOP]});
            ctrl_d.tx_data_sel_a      = gcfg_q[B_TX_SEL_A];
            ctrl_d.tx_data_sel_b      = gcfg_q[B_TX_SEL_B];
            ctrl_d.port_reset         = srst;
            ctrl_d.tx_binary_if       = tcfg_q[B_TX_BIN];
            ctrl_d.tx_clock_invert    = tcfg_q[B_TX_CINV];
            // one attenuator only; transmit placement takes priority
            ctrl_d.tx_jitter_atten_en = tcfg_q[B_TX_JA];
            ctrl_d.rx_jitter_atten_en = rcfg_q[B_RX_JA] & ~tcfg_q[B_TX_JA];
            ctrl_d.tx_power_down      = tcfg_q[B_TX_PD];
            ctrl_d.tx_line_hiz        = tcfg_q[B_TX_PD] | tcfg_q[B_TX_TS]
                                      | ~st.tx_tristate_pin_n;
            ctrl_d.tx_build_out       = tcfg_q[B_TX_LBO] & ~is_euro;
            ctrl_d.rx_binary_if       = rcfg_q[B_RX_BIN];
            ctrl_d.rx_clock_invert    = rcfg_q[B_RX_CINV];
            ctrl_d.rx_power_down      = rcfg_q[B_RX_PD];
            ctrl_d.rx_out_hiz         = rcfg_q[B_RX_PD] | rcfg_q[B_RX_TS]
                                      | ~st.rx_tristate_pin_n;
            ctrl_d.monitor_preamp_en  = rcfg_q[B_RX_MON];
            // violation pin exists only on the binary receive interface
            ctrl_d.rx_violation_out   = rcfg_q[B_RX_BIN] & cv_ev;
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               gcfg_q <= GCFG_RST;
               tcfg_q <= TCFG_RST;
               rcfg_q <= RCFG_RST;
               lat_q  <= ZERO8;
               ien_q  <= ZERO8;
               run_q  <= '0;
               cnt_q  <= '0;
               snap_q <= '0;
               upd_q  <= 1'b0;
            end else begin
               gcfg_q <= gcfg_d;
               tcfg_q <= tcfg_d;
               rcfg_q <= rcfg_d;
               lat_q  <= lat_d;
               ien_q  <= ien_d;
               run_q  <= run_d;
               cnt_q  <= cnt_d;
               snap_q <= snap_d;
               upd_q  <= rcfg_q[B_CV_UPD];
            end
         end

         // edge references: lock and loss start high so reset is not an event
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               drv_q  <= 1'b0;
               pat_q  <= 1'b0;
               pll_q  <= 1'b1;
               los_q  <= 1'b1;
               berr_q <= 1'b0;
               tgl_q  <= 1'b0;
            end else begin
               drv_q  <= st.drv_fault;
               pat_q  <= st.pattern_oos;
               pll_q  <= st.pll_unlocked;
               los_q  <= st.signal_lost;
               berr_q <= st.bit_error;
               tgl_q  <= st.rx_bit_tgl;
            end
         end

         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               ctrl_out[p] <= '0;
            end else begin
               ctrl_out[p] <= ctrl_d;
            end
         end

         always_comb begin
            rd_port[p] = ZERO8;
            if (bus_reg == OFS_GLOBAL_CFG) begin
               rd_port[p] = gcfg_q;
            end else if (bus_reg == OFS_TX_CFG) begin
               rd_port[p] = tcfg_q;
            end else if (bus_reg == OFS_RX_CFG) begin
               rd_port[p] = rcfg_q;
            end else if (bus_reg == OFS_RT_STATUS) begin
               rd_port[p] = rt_stat;
            end else if (bus_reg == OFS_LAT_STATUS) begin
               rd_port[p] = lat_q;
            end else if (bus_reg == OFS_IRQ_EN) begin
               rd_port[p] = ien_q;
            end else if (bus_reg == OFS_CV_LOW) begin
               rd_port[p] = snap_q[7:0];
            end else if (bus_reg == OFS_CV_HIGH) begin
               rd_port[p] = snap_q[15:8];
            end
         end
      end
   endgenerate

   // absent ports and test locations read back zero
   always_comb begin
      rdata_d = ZERO8;
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (bus_port == PORT_W'(i)) begin
            rdata_d = rd_port[i];
         end
      end
   end

   // zero outside a read
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cpu_rdata      <= ZERO8;
         cpu_rdata_oe_n <= 1'b1;
         int_n          <= 1'b1;
      end else begin
         cpu_rdata      <= rd_act ? rdata_d : ZERO8;
         cpu_rdata_oe_n <= ~rd_act;
         int_n          <= ~(|irq_port);
      end
   end
endmodule : lic_regs

// >>> tb/lic_regs_properties.sv
// concurrent checks of the register bank pins
`timescale 1ns/1ps
module lic_regs_properties
   import lic_pkg::*;
#(
   parameter int NUM_PORTS = 4
) (
   input wire logic                  clk,
   input wire logic                  rst_n,
   input wire logic                  cpu_cs_n,
   input wire logic                  cpu_wr_n,
   input wire logic                  cpu_rd_n,
   input wire logic [LIC_ADDR_W-1:0] cpu_addr,
   input wire logic [LIC_DATA_W-1:0] cpu_wdata,
   input wire logic [LIC_DATA_W-1:0] cpu_rdata,
   input wire logic                  cpu_rdata_oe_n,
   input wire logic                  int_n,
   input wire lic_stat_s             stat_in  [NUM_PORTS],
   input wire lic_ctrl_s             ctrl_out [NUM_PORTS]
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // bus and pin runs cover two sync flops plus the output register
   sequence rd_held;
      (!cpu_cs_n && !cpu_rd_n) [*4];
   endsequence
   sequence bus_idle;
      cpu_cs_n [*5];
   endsequence
   sequence tx_pin_low;
      !stat_in[0].tx_tristate_pin_n [*5];
   endsequence
   sequence in_e3;
      ctrl_out[0].mode == LIC_MODE_E3 [*2];
   endsequence
   sequence soft_reset;
      ctrl_out[0].port_reset [*3];
   endsequence
   AST_RD_ANSWER: assert property (rd_held |-> !cpu_rdata_oe_n)
      else $error("read strobe not answered");
   AST_IDLE_QUIET: assert property (bus_idle |-> cpu_rdata_oe_n && cpu_rdata == ZERO8)
      else $error("read data driven while bus idle");
   AST_TX_PIN_HIZ: assert property (tx_pin_low |-> ctrl_out[0].tx_line_hiz)
      else $error("transmit tri-state pin ignored");
   AST_TX_JA_WINS: assert property (
      ctrl_out[0].tx_jitter_atten_en |-> !ctrl_out[0].rx_jitter_atten_en)
      else $error("attenuator in both paths");
   AST_E3_NO_LBO: assert property (in_e3 |-> !ctrl_out[0].tx_build_out)
      else $error("build-out applied in e3");
   AST_LOOP_HOLD: assert property (bus_idle |=> $stable(ctrl_out[0].loop_sel))
      else $error("loopback changed without a write");
   AST_VIOL_BIN: assert property (
      ctrl_out[0].rx_violation_out |-> ctrl_out[0].rx_binary_if)
      else $error("violation flag outside binary mode");
   AST_SOFT_RESET: assert property (soft_reset |-> ctrl_out[0].loop_sel == LIC_LOOP_NONE
      && ctrl_out[0].tx_line_hiz && ctrl_out[0].rx_out_hiz)
      else $error("port reset left config active");
endmodule : lic_regs_properties

bind lic_regs lic_regs_properties #(.NUM_PORTS(NUM_PORTS)) props_u (
   .clk(clk), .rst_n(rst_n), .cpu_cs_n(cpu_cs_n), .cpu_wr_n(cpu_wr_n), .cpu_rd_n(cpu_rd_n),
   .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
   .cpu_rdata_oe_n(cpu_rdata_oe_n), .int_n(int_n), .stat_in(stat_in), .ctrl_out(ctrl_out)
);

// >>> tb/lic_host_model.sv
// host processor model for the parallel cpu bus
`timescale 1ns/1ps
module lic_host_model
   import lic_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic [LIC_DATA_W-1:0] cpu_rdata,
   input  wire logic                  cpu_rdata_oe_n,
   output logic                       cpu_cs_n,
   output logic                       cpu_wr_n,
   output logic                       cpu_rd_n,
   output logic      [LIC_ADDR_W-1:0] cpu_addr,
   output logic      [LIC_DATA_W-1:0] cpu_wdata
);
   initial begin
      {cpu_cs_n, cpu_wr_n, cpu_rd_n} = 3'h7;
      cpu_addr = '0;
      cpu_wdata = '0;
   end
   // hold 4 clocks, then scramble so stale values never help
   task automatic idle_gap();
      repeat (4) @(posedge clk);
      cpu_addr  <= ~cpu_addr;
      cpu_wdata <= ~cpu_wdata;
   endtask : idle_gap
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk);
      cpu_addr  <= a;
      cpu_wdata <= d;
      @(posedge clk);
      {cpu_cs_n, cpu_wr_n} <= 2'h0;
      repeat (5) @(posedge clk);
      {cpu_cs_n, cpu_wr_n} <= 2'h3;
      idle_gap();
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [7:0] d, output logic ok);
      ok = 1'b0;
      @(posedge clk);
      cpu_addr <= a;
      @(posedge clk);
      {cpu_cs_n, cpu_rd_n} <= 2'h0;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge clk);
         ok = (cpu_rdata_oe_n === 1'b0);
      end
      d = cpu_rdata;
      {cpu_cs_n, cpu_rd_n} <= 2'h3;
      idle_gap();
   endtask : rd
endmodule : lic_host_model

// >>> tb/test_line_interface_ctrl_status_regs.sv
// self-checking bench for the line interface control and status registers
`timescale 1ns/1ps
module test_line_interface_ctrl_status_regs
   import lic_pkg::*;
();
   localparam int         NP          = 3;
   localparam logic [7:0] RST_TAB [8] = '{8'h00, 8'h04, 8'h04, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam int         SRC_BIT [5] = '{6, 10, 9, 8, 7};
   localparam logic [7:0] LAT_BIT [5] = '{8'h08, 8'h20, 8'h10, 8'h02, 8'h01};
   logic                  clk, rst_n, cpu_cs_n, cpu_wr_n, cpu_rd_n, cpu_rdata_oe_n, int_n;
   logic [LIC_ADDR_W-1:0] cpu_addr;
   logic [LIC_DATA_W-1:0] cpu_wdata, cpu_rdata;
   lic_stat_s             stat_in  [NP];
   lic_ctrl_s             ctrl_out [NP];
   int                    mismatches, n_compared;
   logic [31:0]           seed = 32'hFC537D46;

   lic_regs #(.NUM_PORTS(NP)) dut_u (.clk(clk), .rst_n(rst_n), .cpu_cs_n(cpu_cs_n),
      .cpu_wr_n(cpu_wr_n), .cpu_rd_n(cpu_rd_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .cpu_rdata_oe_n(cpu_rdata_oe_n), .int_n(int_n),
      .stat_in(stat_in), .ctrl_out(ctrl_out));
   lic_host_model host_u (.clk(clk), .cpu_rdata(cpu_rdata), .cpu_rdata_oe_n(cpu_rdata_oe_n),
      .cpu_cs_n(cpu_cs_n), .cpu_wr_n(cpu_wr_n), .cpu_rd_n(cpu_rd_n), .cpu_addr(cpu_addr),
      .cpu_wdata(cpu_wdata));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic lic_ctrl_s exp_ctrl(logic [7:0] g, t, r, logic [1:0] pn);
      lic_ctrl_s c;
      c.mode = !g[7] ? LIC_MODE_DS3 : (g[6] ? LIC_MODE_STS1 : LIC_MODE_E3);
      c.ds3_ais_alt = !g[7] && g[6];
      c.loop_sel = lic_loop_e'(g[5:4]);
      {c.tx_data_sel_a, c.tx_data_sel_b, c.port_reset} = {g[3], g[2], g[0]};
      {c.tx_binary_if, c.tx_clock_invert, c.tx_jitter_atten_en, c.tx_power_down} = t[6:3];
      c.rx_jitter_atten_en = r[4] && !t[4];
      c.tx_line_hiz = t[3] || t[2] || !pn[1];
      c.tx_build_out = t[1] && c.mode != LIC_MODE_E3;
      {c.rx_binary_if, c.rx_clock_invert, c.rx_power_down} = {r[6:5], r[3]};
      {c.rx_out_hiz, c.monitor_preamp_en, c.rx_violation_out} = {r[3] | r[2] | ~pn[0], r[1], 1'b0};
      return c;
   endfunction : exp_ctrl
   function automatic logic [7:0] exp_cv(logic e3, logic vm);
      return vm ? (e3 ? 8'h00 : 8'h01) : (e3 ? 8'h02 : 8'h03);
   endfunction : exp_cv
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic rdc(input logic [5:0] a, input logic [7:0] e, input string what);
      logic [7:0] d;
      logic       ok;
      host_u.rd(a, d, ok);
      if (!ok) begin
         mismatches++;
         results();
      end
      chk(what, 32'(d), 32'(e));
   endtask : rdc
   task automatic tog(input int p, input int b);
      @(posedge clk);
      stat_in[p][b] <= ~stat_in[p][b];
      repeat (8) @(posedge clk);
   endtask : tog
   task automatic sbit(input logic z, input logic bpv);
      @(posedge clk);
      {stat_in[0].rx_zero, stat_in[0].bpv_any} <= {z, bpv};
      stat_in[0].rx_bit_tgl <= ~stat_in[0].rx_bit_tgl;
      repeat (4) @(posedge clk);
   endtask : sbit

   initial begin
      logic [31:0] x;
      logic [7:0]  g, t, r;
      int          p;
      rst_n = 1'b0;
      foreach (stat_in[i]) stat_in[i] = '{pll_unlocked: 1, signal_lost: 1,
         tx_tristate_pin_n: 1, rx_tristate_pin_n: 1, default: 0};
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      for (int a = 0; a < 8; a++) rdc(a[5:0], RST_TAB[a], "reset value");
      host_u.wr(6'h31, 8'h7E);
      rdc(6'h31, 8'h00, "absent port");
      rdc(6'h08, 8'h00, "unmapped offset");
      // random configurations, the tri-state pins drawn as well
      for (int i = 0; i < 9; i++) begin
         p = i % NP;
         x = rnd();
         {g, t, r} = {x[7:0] & GCFG_MASK & 8'hFE, x[15:8] & TCFG_MASK, x[23:16]};
         @(posedge clk);
         {stat_in[p].tx_tristate_pin_n, stat_in[p].rx_tristate_pin_n} <= x[25:24];
         host_u.wr({p[1:0], OFS_GLOBAL_CFG}, g);
         host_u.wr({p[1:0], OFS_TX_CFG}, t);
         host_u.wr({p[1:0], OFS_RX_CFG}, r);
         rdc({p[1:0], OFS_GLOBAL_CFG}, g, "global config");
         rdc({p[1:0], OFS_TX_CFG}, t, "transmit config");
         chk("controls", 32'(ctrl_out[p]), 32'(exp_ctrl(g, t, r, x[25:24])));
      end
      // soft reset of port 0 holds the rest at defaults
      host_u.wr(6'h00, 8'hB1);
      rdc(6'h00, GCFG_RESET_BIT, "global config in reset");
      host_u.wr(6'h01, 8'h00);
      rdc(6'h01, TCFG_RST, "transmit config in reset");
      host_u.wr(6'h00, 8'h00);
      rdc(6'h02, RCFG_RST, "receive config after reset");
      // latched events of port 1, alternately cleared and masked
      host_u.wr(6'h15, IEN_MASK);
      for (int k = 0; k < 5; k++) begin
         tog(1, SRC_BIT[k]);
         rdc(6'h13, {2'h0, stat_in[1][10:9], 2'h0, stat_in[1][8:7]}, "realtime");
         rdc(6'h14, LAT_BIT[k], "latched status");
         chk("interrupt raised", 32'(int_n), 32'h0);
         host_u.wr(k[0] ? 6'h15 : 6'h14, k[0] ? 8'h00 : LAT_BIT[k]);
         chk("interrupt withdrawn", 32'(int_n), 32'h1);
         rdc(6'h14, k[0] ? LAT_BIT[k] : 8'h00, "latch after clear or mask");
         host_u.wr(6'h14, LAT_BIT[k]);
         host_u.wr(6'h15, IEN_MASK);
      end
      tog(1, 6);
      tog(1, 6);
      rdc(6'h14, 8'h00, "bit error out of sync");
      // violation counting in ds3 and e3 modes, in each violation mode
      for (int c = 0; c < 4; c++) begin
         r = {c[1], 7'h40};
         host_u.wr(6'h00, c[0] ? 8'h80 : 8'h00);
         host_u.wr(6'h02, r | 8'h01);
         host_u.wr(6'h02, r);
         sbit(1'b0, 1'b0);
         repeat (4) sbit(1'b1, 1'b0);
         sbit(1'b0, 1'b0);
         repeat (3) sbit(1'b1, 1'b0);
         sbit(1'b0, 1'b1);
         host_u.wr(6'h02, r | 8'h01);
         rdc(6'h06, exp_cv(c[0], c[1]), "count low byte");
         rdc(6'h07, 8'h00, "count high byte");
         host_u.wr(6'h02, r);
      end
      results();
   end
endmodule : test_line_interface_ctrl_status_regs
